//--- cdps_regs.sv
// Purpose: Channel 7 integer/fractional divider registers and read-only PLL status register.
// Assumes: The serial configuration port decodes frames into single-cycle register accesses.
// Notes:   Monitor inputs are synchronous to sys_clk; read data appears one cycle after the strobe.
`timescale 1ns/1ns

// Operation
// [R1] Register 0x13 bits 11:4 set the channel 7 integer divide, which is the field plus one.
// [R2] Bits 3:0 of register 0x13 hold fraction bits 19:16 of channel 7.
// [R3] Register 0x14 holds fraction bits 15:0 of channel 7 across its full width.
// [R4] The host writes zero to bits 15:12 of register 0x13 because they are reserved.
// [R5] Bits 15:3 of the status register always read as zero.
// [R6] The status register is read only and host writes to it change nothing.
// [R7] Status bit 2 reads 0 while the PLL is locked and 1 while it is unlocked.
// [R8] The external lock output uses the opposite polarity: high for lock, low for unlock.
// [R9] Status bit 1 reads 1 when the reference is lost in the observation window, else 0.
// [R10] Status bit 0 reads 0 for the primary reference and 1 for the secondary one.
// [R11] The fraction is applied only while the fraction path enable bit is 1.
// [R12] With the fraction path on, pre-divide code 000 gives 2, 001 gives 3, 111 gives 1.
// [R13] The effective ratio is the integer value plus one plus the fraction over two to the 20.
module cdps_regs (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr_en,
	input  wire logic [15:0] reg_wr_data,
	input  wire logic        reg_rd_en,
	output logic      [15:0] reg_rd_data,
	output logic             reg_rd_valid,
	input  wire logic        pll_locked,
	input  wire logic        ref_loss_in_window,
	input  wire logic        ref_secondary_selected,
	input  wire logic        ch7_fraction_path_on,
	input  wire logic [2:0]  ch7_prescale_code,
	output logic             pll_lock_status_out,
	output logic      [7:0]  ch7_integer_ratio,
	output logic      [8:0]  ch7_divide_value,
	output logic      [19:0] ch7_fraction_value,
	output logic      [1:0]  ch7_prescale_factor,
	output logic             ch7_prescale_code_bad,
	output logic      [28:0] ch7_effective_ratio
);

	// ----------------------------------------------------------------
	// Stored registers
	// ----------------------------------------------------------------
	logic [11:0] int_frac_high_reg;
	logic [11:0] int_frac_high_next;
	logic [15:0] frac_low_reg;
	logic [15:0] frac_low_next;
	logic [2:0]  status_reg;
	logic [2:0]  status_next;
	logic [15:0] rd_data_reg;
	logic [15:0] rd_data_next;
	logic        rd_valid_reg;
	logic        lock_out_reg;
	logic [7:0]  int_ratio_reg;
	logic [8:0]  div_value_reg;
	logic [8:0]  div_value_next;
	logic [19:0] frac_value_reg;
	logic [19:0] frac_value_next;
	logic [1:0]  pre_factor_reg;
	logic [1:0]  pre_factor_next;
	logic        pre_bad_reg;
	logic        pre_bad_next;
	logic [28:0] eff_ratio_reg;
	logic [28:0] eff_ratio_next;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire logic        hit_int_frac_high = (reg_addr == cdps_pkg::CDPS_ADDR_INT_FRAC_HIGH);
	wire logic        hit_frac_low      = (reg_addr == cdps_pkg::CDPS_ADDR_FRAC_LOW);
	wire logic        hit_status        = (reg_addr == cdps_pkg::CDPS_ADDR_STATUS);
	wire logic        wr_int_frac_high  = reg_wr_en && hit_int_frac_high;
	wire logic        wr_frac_low       = reg_wr_en && hit_frac_low;

	// Reserved bits 15:12 are not stored; the host keeps them at zero.
	assign int_frac_high_next = wr_int_frac_high ? reg_wr_data[11:0] : int_frac_high_reg; // [R4]
	assign frac_low_next      = wr_frac_low ? reg_wr_data : frac_low_reg; // [R3]

	// ----------------------------------------------------------------
	// Status capture
	// ----------------------------------------------------------------
	// No write path reaches status_reg, so a write to its index is dropped.
	assign status_next[cdps_pkg::CDPS_ST_UNLOCK_BIT]   = ~pll_locked; // [R7]
	assign status_next[cdps_pkg::CDPS_ST_REF_LOSS_BIT] = ref_loss_in_window; // [R9]
	assign status_next[cdps_pkg::CDPS_ST_REF_SEL_BIT]  = ref_secondary_selected; // [R10]

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	wire logic [15:0] rd_int_frac_high  = {4'h0, int_frac_high_reg};
	wire logic [15:0] rd_status         = {13'h0000, status_reg}; // [R5]
	assign rd_data_next = !reg_rd_en        ? rd_data_reg :
	                      hit_int_frac_high ? rd_int_frac_high :
	                      hit_frac_low      ? frac_low_reg :
	                      hit_status        ? rd_status :
	                                          16'h0000;

	// ----------------------------------------------------------------
	// Divider datapath settings
	// ----------------------------------------------------------------
	wire logic [7:0]  int_field  = int_frac_high_reg[cdps_pkg::CDPS_INT_MSB:cdps_pkg::CDPS_INT_LSB];
	wire logic [3:0]  frac_high  =
		int_frac_high_reg[cdps_pkg::CDPS_FRAC_HIGH_MSB:cdps_pkg::CDPS_FRAC_HIGH_LSB]; // [R2]
	wire logic [19:0] frac_field = {frac_high, frac_low_reg}; // [R2] [R3]

	assign div_value_next  = {1'b0, int_field} + 9'h001; // [R1]
	assign frac_value_next = ch7_fraction_path_on ? frac_field : 20'h00000; // [R11]
	assign eff_ratio_next  = {div_value_next, frac_value_next}; // [R13]

	// Pre-divider is bypassed (factor 1) whenever the fraction path is off.
	wire logic        code_div2  = (ch7_prescale_code == cdps_pkg::CDPS_PRE_DIV2);
	wire logic        code_div3  = (ch7_prescale_code == cdps_pkg::CDPS_PRE_DIV3);
	wire logic        code_div1  = (ch7_prescale_code == cdps_pkg::CDPS_PRE_DIV1);
	assign pre_factor_next = !ch7_fraction_path_on ? cdps_pkg::CDPS_PRE_FACTOR1 :
	                         code_div2             ? cdps_pkg::CDPS_PRE_FACTOR2 :
	                         code_div3             ? cdps_pkg::CDPS_PRE_FACTOR3 :
	                                                 cdps_pkg::CDPS_PRE_FACTOR1; // [R12]
	// Reserved codes fall back to divide by 1 and are flagged only while the fraction path is on.
	assign pre_bad_next    = ch7_fraction_path_on && !(code_div2 || code_div3 || code_div1); // [R12]

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Each group of flip-flops sits in its own short block; every one of them
	// resets synchronously and loads on every edge.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			int_frac_high_reg <= cdps_pkg::CDPS_RST_INT_FRAC_HIGH[11:0];
		end else begin
			int_frac_high_reg <= int_frac_high_next; // [R1] [R2]
		end
	end

	// The fraction halves are written on separate edges, so the datapath can
	// carry a mixed fraction until the second half lands.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			frac_low_reg <= cdps_pkg::CDPS_RST_FRAC_LOW;
		end else begin
			frac_low_reg <= frac_low_next; // [R3]
		end
	end

	// Monitor levels are captured every edge, so a read reports them two edges
	// after they change.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			status_reg <= 3'h0;
		end else begin
			status_reg <= status_next; // [R6]
		end
	end

	// Read data holds until the next read so a slow host can still pick it up.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_data_reg  <= 16'h0000;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_data_reg  <= rd_data_next;
			rd_valid_reg <= reg_rd_en;
		end
	end

	// The lock pin carries the inverse of status bit 2.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			lock_out_reg <= 1'b0;
		end else begin
			lock_out_reg <= pll_locked; // [R8]
		end
	end

	// Derived outputs follow the stored fields one edge later.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			int_ratio_reg <= 8'h00;
			div_value_reg <= 9'h001;
		end else begin
			int_ratio_reg <= int_field; // [R1]
			div_value_reg <= div_value_next; // [R1]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			frac_value_reg <= 20'h00000;
		end else begin
			frac_value_reg <= frac_value_next; // [R11]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pre_factor_reg <= cdps_pkg::CDPS_PRE_FACTOR1;
			pre_bad_reg    <= 1'b0;
		end else begin
			pre_factor_reg <= pre_factor_next; // [R12]
			pre_bad_reg    <= pre_bad_next; // [R12]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			eff_ratio_reg <= 29'h00000000;
		end else begin
			eff_ratio_reg <= eff_ratio_next; // [R13]
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rd_data           = rd_data_reg;
	assign reg_rd_valid          = rd_valid_reg;
	assign pll_lock_status_out   = lock_out_reg;
	assign ch7_integer_ratio     = int_ratio_reg;
	assign ch7_divide_value      = div_value_reg;
	assign ch7_fraction_value    = frac_value_reg;
	assign ch7_prescale_factor   = pre_factor_reg;
	assign ch7_prescale_code_bad = pre_bad_reg;
	assign ch7_effective_ratio   = eff_ratio_reg;

endmodule

//--- cdps_pkg.sv
// Purpose: Shared constants for the channel 7 divider and PLL status register slice.
// Assumes: 16-bit configuration registers reached by a register index over the serial port.
// Notes:   Offsets are register indices as seen by the configuration port.
package cdps_pkg;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [7:0]  CDPS_ADDR_INT_FRAC_HIGH = 8'h13;
	localparam logic [7:0]  CDPS_ADDR_FRAC_LOW      = 8'h14;
	localparam logic [7:0]  CDPS_ADDR_STATUS        = 8'h15;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [15:0] CDPS_RST_INT_FRAC_HIGH  = 16'h0040;
	localparam logic [15:0] CDPS_RST_FRAC_LOW       = 16'h7940;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          CDPS_INT_MSB            = 11;
	localparam int          CDPS_INT_LSB            = 4;
	localparam int          CDPS_FRAC_HIGH_MSB      = 3;
	localparam int          CDPS_FRAC_HIGH_LSB      = 0;
	localparam int          CDPS_ST_UNLOCK_BIT      = 2;
	localparam int          CDPS_ST_REF_LOSS_BIT    = 1;
	localparam int          CDPS_ST_REF_SEL_BIT     = 0;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int          CDPS_INT_W              = 8;
	localparam int          CDPS_FRAC_W             = 20;
	localparam int          CDPS_REG_W              = 16;

	// ----------------------------------------------------------------
	// Pre-divider codes and resulting divide factors
	// ----------------------------------------------------------------
	localparam logic [2:0]  CDPS_PRE_DIV2           = 3'h0;
	localparam logic [2:0]  CDPS_PRE_DIV3           = 3'h1;
	localparam logic [2:0]  CDPS_PRE_DIV1           = 3'h7;
	localparam logic [1:0]  CDPS_PRE_FACTOR1        = 2'h1;
	localparam logic [1:0]  CDPS_PRE_FACTOR2        = 2'h2;
	localparam logic [1:0]  CDPS_PRE_FACTOR3        = 2'h3;

endpackage

//--- cdps_regs_props.sv
// Purpose: Checker for the channel 7 divider and PLL status register slice.
// Assumes: Strobes and monitor inputs are synchronous to sys_clk.
// Notes:   Attached to the register slice by bind.
`timescale 1ns/1ns
module cdps_regs_props (
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_rd_en,
	input wire logic [15:0] reg_rd_data,
	input wire logic        reg_rd_valid,
	input wire logic        pll_locked,
	input wire logic        ref_loss_in_window,
	input wire logic        ref_secondary_selected,
	input wire logic        ch7_fraction_path_on,
	input wire logic [2:0]  ch7_prescale_code,
	input wire logic        pll_lock_status_out,
	input wire logic [7:0]  ch7_integer_ratio,
	input wire logic [8:0]  ch7_divide_value,
	input wire logic [19:0] ch7_fraction_value,
	input wire logic [1:0]  ch7_prescale_factor,
	input wire logic        ch7_prescale_code_bad,
	input wire logic [28:0] ch7_effective_ratio
);
	wire logic [1:0] exp_fac;
	wire logic       exp_bad;
	wire logic       st_rd;
	assign exp_fac = !ch7_fraction_path_on ? cdps_pkg::CDPS_PRE_FACTOR1 :
		(ch7_prescale_code == cdps_pkg::CDPS_PRE_DIV2) ? cdps_pkg::CDPS_PRE_FACTOR2 :
		(ch7_prescale_code == cdps_pkg::CDPS_PRE_DIV3) ? cdps_pkg::CDPS_PRE_FACTOR3 :
		cdps_pkg::CDPS_PRE_FACTOR1;
	assign exp_bad = ch7_fraction_path_on &&
		ch7_prescale_code != cdps_pkg::CDPS_PRE_DIV2 &&
		ch7_prescale_code != cdps_pkg::CDPS_PRE_DIV3 &&
		ch7_prescale_code != cdps_pkg::CDPS_PRE_DIV1;
	assign st_rd = reg_rd_en && reg_addr == cdps_pkg::CDPS_ADDR_STATUS;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	rd_valid_pulse_a: assert property (
		!$past(srst) |-> reg_rd_valid == $past(reg_rd_en))
		else $error("read valid does not follow strobe");
	lock_pin_a: assert property (
		!$past(srst) |-> pll_lock_status_out == $past(pll_locked))
		else $error("lock pin wrong");
	status_zero_a: assert property (
		st_rd |=> reg_rd_data[15:3] == 13'h0000)
		else $error("status reserved bits set");
	status_bits_a: assert property (
		st_rd && !$past(srst) |=> reg_rd_data[2:0] == {~$past(pll_locked, 2),
		$past(ref_loss_in_window, 2), $past(ref_secondary_selected, 2)})
		else $error("status bits wrong");
	divide_plus_a: assert property (
		ch7_divide_value == {1'b0, ch7_integer_ratio} + 9'h001)
		else $error("divide value wrong");
	frac_off_a: assert property (
		!$past(srst) && !$past(ch7_fraction_path_on) |-> ch7_fraction_value == 20'h00000)
		else $error("fraction not zero");
	eff_ratio_a: assert property (
		!$past(srst) |-> ch7_effective_ratio == {ch7_divide_value, ch7_fraction_value})
		else $error("effective ratio wrong");
	prescale_map_a: assert property (
		!$past(srst) |-> ch7_prescale_factor == $past(exp_fac) &&
		ch7_prescale_code_bad == $past(exp_bad))
		else $error("prescale wrong");
endmodule
bind cdps_regs cdps_regs_props chk (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
	.reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
	.pll_locked(pll_locked), .ref_loss_in_window(ref_loss_in_window),
	.ref_secondary_selected(ref_secondary_selected), .ch7_fraction_path_on(ch7_fraction_path_on),
	.ch7_prescale_code(ch7_prescale_code), .pll_lock_status_out(pll_lock_status_out),
	.ch7_integer_ratio(ch7_integer_ratio), .ch7_divide_value(ch7_divide_value),
	.ch7_fraction_value(ch7_fraction_value), .ch7_prescale_factor(ch7_prescale_factor),
	.ch7_prescale_code_bad(ch7_prescale_code_bad), .ch7_effective_ratio(ch7_effective_ratio));

//--- cdps_regs_tb_top.sv
// Purpose: Self-checking bench for the channel 7 divider and PLL status register slice.
// Assumes: Inputs change 2 ns after the rising edge of sys_clk.
// Notes:   Read data is sampled in the cycle where the read valid pulse stands.
`timescale 1ns/1ns
module cdps_regs_tb_top;
	logic        sys_clk, srst, reg_wr_en, reg_rd_en, pll_locked, ref_loss_in_window;
	logic        ref_secondary_selected, ch7_fraction_path_on, reg_rd_valid, ch7_prescale_code_bad;
	logic        pll_lock_status_out;
	logic [7:0]  reg_addr, ch7_integer_ratio;
	logic [15:0] reg_wr_data, reg_rd_data, rdat, est;
	logic [2:0]  ch7_prescale_code;
	logic [8:0]  ch7_divide_value;
	logic [19:0] ch7_fraction_value;
	logic [1:0]  ch7_prescale_factor, efac;
	logic [28:0] ch7_effective_ratio;
	int          err_count, compares;
	cdps_regs dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
		.reg_rd_valid(reg_rd_valid), .pll_locked(pll_locked), .ref_loss_in_window(ref_loss_in_window),
		.ref_secondary_selected(ref_secondary_selected), .ch7_fraction_path_on(ch7_fraction_path_on),
		.ch7_prescale_code(ch7_prescale_code), .pll_lock_status_out(pll_lock_status_out),
		.ch7_integer_ratio(ch7_integer_ratio), .ch7_divide_value(ch7_divide_value),
		.ch7_fraction_value(ch7_fraction_value), .ch7_prescale_factor(ch7_prescale_factor),
		.ch7_prescale_code_bad(ch7_prescale_code_bad), .ch7_effective_ratio(ch7_effective_ratio));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic chk(input string name, input logic [28:0] exp, input logic [28:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr    = a;
		reg_wr_data = d;
		reg_wr_en   = 1'b1;
		step(1);
		reg_wr_en   = 1'b0;
		step(1);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr  = a;
		reg_rd_en = 1'b1;
		step(1);
		reg_rd_en = 1'b0;
		chk("rd_valid", 29'h1, reg_rd_valid);
		rdat = reg_rd_data;
		step(1);
		chk("rd_valid_low", 29'h0, reg_rd_valid);
	endtask
	task automatic final_report;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic t_fields;
		rd(8'h13);
		chk("reset_13", cdps_pkg::CDPS_RST_INT_FRAC_HIGH, rdat);
		rd(8'h14);
		chk("reset_14", cdps_pkg::CDPS_RST_FRAC_LOW, rdat);
		wr(8'h13, 16'h0AB5);
		wr(8'h14, 16'h1234);
		rd(8'h13);
		chk("rb_13", 29'h0AB5, rdat);
		rd(8'h14);
		chk("rb_14", 29'h1234, rdat);
		chk("ratio", 29'h0AB, ch7_integer_ratio);
		chk("div", 29'h0AC, ch7_divide_value);
		chk("frac", 29'h51234, ch7_fraction_value);
		chk("eff", {9'h0AC, 20'h51234}, ch7_effective_ratio);
		wr(8'h13, 16'h0FF0);
		wr(8'h14, 16'hFFFF);
		step(1);
		chk("div_max", 29'h100, ch7_divide_value);
		chk("frac_lo", 29'h0FFFF, ch7_fraction_value);
	endtask
	task automatic t_prescale;
		for (int c = 0; c < 8; c++) begin
			ch7_prescale_code    = 3'(c);
			ch7_fraction_path_on = 1'b1;
			step(2);
			efac = (c == 0) ? 2'h2 : (c == 1) ? 2'h3 : 2'h1;
			chk("factor", efac, ch7_prescale_factor);
			chk("bad", (c > 1 && c < 7), ch7_prescale_code_bad);
			chk("frac_on", 29'h0FFFF, ch7_fraction_value);
			ch7_fraction_path_on = 1'b0;
			step(2);
			chk("frac_off", 29'h0, ch7_fraction_value);
			chk("fac_off", 29'h1, ch7_prescale_factor);
			chk("bad_off", 29'h0, ch7_prescale_code_bad);
		end
	endtask
	task automatic t_status;
		for (int i = 0; i < 8; i++) begin
			{pll_locked, ref_loss_in_window, ref_secondary_selected} = 3'(i);
			step(2);
			rd(8'h15);
			est = {13'h0000, ~pll_locked, ref_loss_in_window, ref_secondary_selected};
			chk("status", est, rdat);
			chk("lock_pin", pll_locked, pll_lock_status_out);
		end
		wr(8'h15, 16'hFFFF);
		rd(8'h15);
		chk("status_ro", 29'h0003, rdat);
		rd(8'h13);
		chk("ro_keep_13", 29'h0FF0, rdat);
		rd(8'h14);
		chk("ro_keep_14", 29'hFFFF, rdat);
		rd(8'h16);
		chk("unmapped", 29'h0, rdat);
	endtask
	task automatic t_reset;
		srst = 1'b1;
		step(2);
		srst = 1'b0;
		step(1);
		chk("valid_rst", 29'h0, reg_rd_valid);
		chk("rst_div", 29'h005, ch7_divide_value);
		rd(8'h13);
		chk("rst_13", cdps_pkg::CDPS_RST_INT_FRAC_HIGH, rdat);
		rd(8'h14);
		chk("rst_14", cdps_pkg::CDPS_RST_FRAC_LOW, rdat);
	endtask
	initial begin
		srst                   = 1'b1;
		reg_addr               = 8'h00;
		reg_wr_en              = 1'b0;
		reg_rd_en              = 1'b0;
		reg_wr_data            = 16'h0000;
		pll_locked             = 1'b1;
		ref_loss_in_window     = 1'b0;
		ref_secondary_selected = 1'b0;
		ch7_fraction_path_on   = 1'b1;
		ch7_prescale_code      = 3'h7;
		err_count              = 0;
		compares               = 0;
		step(5);
		srst = 1'b0;
		step(1);
		t_fields();
		t_prescale();
		t_status();
		t_reset();
		final_report();
	end
	initial begin
		#20000;
		err_count++;
		final_report();
	end
endmodule
